// File: hias_addr_decode.sv
// hias_addr_decode: port address comparator and chip-select merge with dma acknowledge
// assumes address and strobes are synchronous to clock; purely combinational
`timescale 1ns/100ps
module hias_addr_decode #(
    parameter int unsigned ADDR_W = hias_pkg::ADDR_W
) (
    input  wire logic [ADDR_W-1:0] addr,            // host address lines one to eight
    input  wire logic [ADDR_W-1:0] match_value,     // switch-set port address
    input  wire logic              io_read_n,       // host i/o read
    input  wire logic              io_write_n,      // host i/o write
    input  wire logic              addr_qual,       // further address qualifier
    input  wire logic              addr_enable,     // host address enable
    input  wire logic              dma_ack_n,       // dma acknowledge
    output wire logic              match_n,         // address match, active low
    output wire logic              chip_sel_n       // merged chip select, active low
);

    // enable only for i/o cycles, so memory cycles at the same address never match
    wire logic cmp_enable;
    wire logic addr_equal;
    assign cmp_enable = (~io_read_n | ~io_write_n) & addr_qual & ~addr_enable;
    assign addr_equal = (addr == match_value);
    assign match_n    = ~(addr_equal & cmp_enable);
    // dma transfers select the device without a port decode
    assign chip_sel_n = match_n & dma_ack_n;

endmodule // hias_addr_decode

// File: hias_dev_model.sv
// hias_dev_model: behavioural device bank answering strobes with its completion flag
// assumes strobes from the glue; done_n is the wire level including the pull-up
`timescale 1ns/100ps
module hias_dev_model (
    input  wire logic                clock,   // device clock
    input  wire logic                reset_n, // asynchronous reset, active low
    input  wire hias_pkg::hias_dev_t dev,     // strobes from the glue
    input  wire logic                stuck,   // keep the flag busy, as after a bad command
    output logic                     done_n   // completion flag wire level
);
    int busy_cnt;
    // flag moves on falling edges only, so rising-edge samplers see it settled;
    // a seen strobe releases it to the pull-up level, then it is held busy
    always @(negedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 0;
            done_n   <= 1'b0;
        end else if (!(dev.read_n && dev.write_n) && busy_cnt == 0) begin
            busy_cnt <= 6;
            done_n   <= 1'b1;
        end else begin
            busy_cnt <= (busy_cnt > 0) ? busy_cnt - 1 : 0;
            done_n   <= stuck || busy_cnt > 1;
        end
    end
endmodule // hias_dev_model

// File: hias_pkg.sv
// hias_pkg: shared constants and carrier types for the host i/o access synchroniser
// assumes a single 200 MHz clock and active-low host channel strobes
package hias_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_PS     = 5000;        // 200 MHz
    localparam int unsigned READY_MAX_NS      = 2500;        // longest channel-ready low time, ns
    localparam int unsigned READY_MAX_CYC     = (READY_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned WATCHDOG_CYC      = 16;          // device clocks before ready is forced
    localparam int unsigned ADDR_W            = 8;           // host address lines one to eight
    localparam int unsigned CNT_W             = 9;

    // reset values
    localparam logic        STAGE_RESET       = 1'b1;        // sync stages idle high (inactive)
    localparam logic        READY_RESET       = 1'b1;        // channel ready idles high

    // host side inputs travelling together
    typedef struct packed {
        logic              io_read_n;       // host i/o read strobe
        logic              io_write_n;      // host i/o write strobe
        logic              addr_enable;     // high during dma, blocks port decode
        logic              addr_qual;       // further address qualifier, active high
        logic [ADDR_W-1:0] addr;            // host address lines one to eight
        logic              addr0;           // host address bit zero
        logic              dma_ack_n;       // dma acknowledge for the assigned channel
    } hias_host_t;

    // strobes presented to the device bank
    typedef struct packed {
        logic chip_sel_n;                    // device chip select
        logic read_n;                        // device read strobe
        logic write_n;                       // device write strobe
        logic cmd_data;                      // command-or-data select, low selects data
    } hias_dev_t;

endpackage

// File: hias_ready_watchdog.sv
// hias_ready_watchdog: counts device clocks while chip select holds and the device is busy
// assumes chip select and completion flag are synchronous to clock
`timescale 1ns/100ps
module hias_ready_watchdog #(
    parameter int unsigned LIMIT = hias_pkg::WATCHDOG_CYC,
    parameter int unsigned CNT_W = hias_pkg::CNT_W
) (
    input  wire logic clock,          // device clock
    input  wire logic reset_n,        // asynchronous reset, active low
    input  wire logic chip_sel_n,     // merged chip select
    input  wire logic done_n,         // device completion flag, low when idle
    output wire logic expired,        // level: limit reached in this access
    output wire logic expire_pulse    // one-cycle pulse in the last cycle before the limit is reached
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    wire logic        at_limit;

    assign at_limit     = (count_r == CNT_W'(LIMIT));
    assign expired      = at_limit;
    assign expire_pulse = (count_r == CNT_W'(LIMIT - 1)) & ~chip_sel_n & done_n;

    // cleared whenever chip select ends; stops at the limit so the pulse fires once
    always_comb begin
        count_nxt = count_r;
        if (chip_sel_n) begin
            count_nxt = '0;
        end else if (!at_limit && done_n) begin
            count_nxt = count_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule // hias_ready_watchdog

// File: hias_sync.sv
// hias_sync: host-side glue that drives a bank of data manager devices from a pc i/o channel
// assumes host inputs already synchronous to clock, device clock equal to clock
//
// Notes on behaviour
// - device strobes are produced synchronous to the device clock, never asynchronous
// - read and write merge into one request, passed only while completion is low
// - stage a captures on falling edge, stage b asserts on next rising edge
// - synchronised strobe gated with host read or write gives separate strobes
// - stage a goes high on falling edge once busy; stage b follows, ending strobe
// - device strobes stay low exactly two device clocks in falling-edge mode
// - comparator matches address lines one to eight against switch value when enabled
// - comparator enable built from read, write, qualifier and address enable
// - chip select is address match or dma acknowledge
// - channel ready never held low longer than 2.5 microseconds
// - ready idles high, drops on chip select, returns high when stage b low
// - insert as few host wait states as possible
// - busy completion flag at chip select blocks request from both stages
// - rising-edge-only variant samples stage a on rising edge, one extra clock
// - command-or-data follows address bit zero, forced low by dma acknowledge
// - counter forces ready after 16 clocks of busy chip select, raises interrupt
`timescale 1ns/100ps
module hias_sync #(
    parameter int unsigned ADDR_W        = hias_pkg::ADDR_W,
    parameter int unsigned WATCHDOG_CYC  = hias_pkg::WATCHDOG_CYC,
    parameter int unsigned READY_MAX_CYC = hias_pkg::READY_MAX_CYC,
    parameter bit          RISING_ONLY   = 1'b0
) (
    input  wire logic                clock,         // device clock, 200 MHz
    input  wire logic                reset_n,       // asynchronous reset, active low
    input  wire hias_pkg::hias_host_t host,         // host channel inputs
    input  wire logic [ADDR_W-1:0]   match_value,   // switch-set port address
    input  wire logic                done_n,        // device completion flag (pulled-up wire level)
    output hias_pkg::hias_dev_t      dev,           // strobes to the device bank
    output logic                     channel_ready, // host channel ready, high releases host
    output logic                     host_irq,      // watchdog interrupt, registered level
    output logic                     ready_forced   // high while ready was forced by watchdog
);

    // decode and watchdog outputs
    wire logic match_n;
    wire logic chip_sel_n;
    wire logic wd_expired;
    wire logic wd_pulse;

    hias_addr_decode #(
        .ADDR_W      (ADDR_W)
    ) u_decode (
        .addr        (host.addr),
        .match_value (match_value),
        .io_read_n   (host.io_read_n),
        .io_write_n  (host.io_write_n),
        .addr_qual   (host.addr_qual),
        .addr_enable (host.addr_enable),
        .dma_ack_n   (host.dma_ack_n),
        .match_n     (match_n),
        .chip_sel_n  (chip_sel_n)
    );

    hias_ready_watchdog #(
        .LIMIT        (WATCHDOG_CYC),
        .CNT_W        (hias_pkg::CNT_W)
    ) u_watchdog (
        .clock        (clock),
        .reset_n      (reset_n),
        .chip_sel_n   (chip_sel_n),
        .done_n       (done_n),
        .expired      (wd_expired),
        .expire_pulse (wd_pulse)
    );

    // synchroniser and output state; stages and strobes are high when inactive, irq_r is high when set
    logic sync_stage_a_r;
    logic sync_stage_a_fall_r;
    logic sync_stage_a_rise_r;
    logic sync_stage_b_r;
    logic ready_hold_stage_r;
    logic ready_hold_stage_nxt;
    logic irq_r;
    logic cmd_data_r;
    logic read_n_r;
    logic write_n_r;
    logic [hias_pkg::CNT_W-1:0] low_cnt_r;

    // merged access request: either host strobe with chip select, gated by completion
    wire logic access_n;
    wire logic sync_stage_a_in;
    wire logic sync_stage_b_in;
    assign access_n        = host.io_read_n & host.io_write_n;
    // request only enters while completion is low; a busy flag blocks it      
    assign sync_stage_a_in = access_n | chip_sel_n | done_n;
    assign sync_stage_b_in = sync_stage_a_r;

    // stage a source: falling-edge flop normally, rising-edge flop in the one-edge variant
    assign sync_stage_a_r  = RISING_ONLY ? sync_stage_a_rise_r : sync_stage_a_fall_r;

    // falling-edge capture gains half a clock, so the strobe starts one clock sooner than in the rising-edge variant
    always_ff @(negedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_stage_a_fall_r <= hias_pkg::STAGE_RESET;
        end else begin
            sync_stage_a_fall_r <= sync_stage_a_in;
        end
    end

    // rising-edge capture, starts the strobe one clock later at the same width
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_stage_a_rise_r <= hias_pkg::STAGE_RESET;
        end else begin
            sync_stage_a_rise_r <= sync_stage_a_in;
        end
    end

    // second stage on the rising edge gives strobes aligned to the device clock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_stage_b_r <= hias_pkg::STAGE_RESET;
        end else begin
            sync_stage_b_r <= sync_stage_b_in;
        end
    end

    // ready: drop on chip select, release once stage b is low or the watchdog fires
    wire logic release_ready;
    assign release_ready = ~sync_stage_b_r | wd_expired | wd_pulse;
    always_comb begin
        ready_hold_stage_nxt = ready_hold_stage_r;
        if (chip_sel_n) begin
            ready_hold_stage_nxt = 1'b1;
        end else if (release_ready) begin
            ready_hold_stage_nxt = 1'b1;
        end else if (ready_hold_stage_r && sync_stage_b_r && low_cnt_r == '0) begin
            ready_hold_stage_nxt = 1'b0;
        end
    end

    // one low phase per access: low_cnt counts every chip select cycle and never rearms within one select
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ready_hold_stage_r <= hias_pkg::READY_RESET;
            low_cnt_r          <= '0;
        end else begin
            ready_hold_stage_r <= ready_hold_stage_nxt;
            if (chip_sel_n) begin
                low_cnt_r <= '0;
            end else if (low_cnt_r != '1) begin
                low_cnt_r <= low_cnt_r + hias_pkg::CNT_W'(1);
            end
        end
    end

    // hard bound on wait time as a backstop in case the watchdog limit is set too large
    wire logic ready_timeout;
    assign ready_timeout = (low_cnt_r >= hias_pkg::CNT_W'(READY_MAX_CYC - 1));
    assign channel_ready = ready_hold_stage_r | ready_timeout;

    // device strobes: stage b split by host read and write, data outputs registered
    wire logic read_nxt;
    wire logic write_nxt;
    wire logic cmd_data_nxt;
    assign read_nxt     = sync_stage_b_in | host.io_read_n;
    assign write_nxt    = sync_stage_b_in | host.io_write_n;
    assign cmd_data_nxt = host.addr0 & host.dma_ack_n;

    // strobe registers mirror stage b so widths match it exactly
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_n_r   <= 1'b1;
            write_n_r  <= 1'b1;
            cmd_data_r <= 1'b1;
        end else begin
            read_n_r   <= read_nxt;
            write_n_r  <= write_nxt;
            cmd_data_r <= cmd_data_nxt;
        end
    end

    // interrupt stays set until the next access begins, set beats clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
        end else if (wd_pulse) begin
            irq_r <= 1'b1;
        end else if (chip_sel_n && !access_n) begin
            irq_r <= irq_r;
        end else if (!chip_sel_n && wd_expired == 1'b0 && !done_n) begin
            irq_r <= 1'b0;
        end
    end

    assign dev.chip_sel_n = chip_sel_n;
    assign dev.read_n     = read_n_r;
    assign dev.write_n    = write_n_r;
    assign dev.cmd_data   = cmd_data_r;
    assign host_irq       = irq_r;
    assign ready_forced   = wd_expired;

endmodule // hias_sync

// File: hias_sync_asserts.sv
// hias_sync_asserts: port-level timing checks for the host-side glue
// assumes it is bound into hias_sync and sees only that module's ports
`timescale 1ns/100ps
module hias_sync_asserts #(
    parameter int unsigned ADDR_W        = hias_pkg::ADDR_W,
    parameter int unsigned READY_MAX_CYC = hias_pkg::READY_MAX_CYC
) (
    input wire logic                 clock,         // device clock
    input wire logic                 reset_n,       // asynchronous reset, active low
    input wire hias_pkg::hias_host_t host,          // host channel inputs
    input wire logic [ADDR_W-1:0]    match_value,   // switch-set port address
    input wire logic                 done_n,        // completion flag level
    input wire hias_pkg::hias_dev_t  dev,           // device strobes
    input wire logic                 channel_ready, // host channel ready
    input wire logic                 host_irq,      // watchdog interrupt
    input wire logic                 ready_forced   // ready forced by watchdog
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    int unsigned low_cnt;
    // run length of ready low; too long would starve host memory refresh
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) low_cnt <= 0;
        else low_cnt <= channel_ready ? 0 : low_cnt + 1;
    end
    // strobe steps
    sequence strobe_start;
        $fell(dev.read_n) || $fell(dev.write_n);
    endsequence
    sequence low_then_high(s);
        !s ##1 s;
    endsequence
    write_len_a: assert property ($fell(dev.write_n) |=> low_then_high(dev.write_n))
        else $error("write strobe not two clocks long");
    read_len_a: assert property ($fell(dev.read_n) |=> low_then_high(dev.read_n))
        else $error("read strobe not two clocks long");
    read_gate_a: assert property ($fell(dev.read_n) |-> !$past(host.io_read_n))
        else $error("read strobe without host read");
    idle_gate_a: assert property (strobe_start |-> !$past(done_n))
        else $error("strobe started while device busy");
    ready_back_a: assert property (strobe_start |=> channel_ready)
        else $error("ready not back after strobe valid");
    ready_drop_a: assert property ($fell(dev.chip_sel_n) |=> !channel_ready)
        else $error("ready not dropped on select");
    ready_bound_a: assert property (low_cnt <= READY_MAX_CYC)
        else $error("ready low too long");
    cmd_sel_a: assert property (strobe_start |-> dev.cmd_data == ($past(host.addr0) && $past(host.dma_ack_n)))
        else $error("command select wrong");
    dma_sel_a: assert property (!host.dma_ack_n |-> !dev.chip_sel_n)
        else $error("dma acknowledge without select");
    addr_miss_a: assert property (host.dma_ack_n && host.addr != match_value |-> dev.chip_sel_n)
        else $error("select on wrong address");
    aen_block_a: assert property (host.dma_ack_n && host.addr_enable |-> dev.chip_sel_n)
        else $error("select while address enable high");
    irq_ready_a: assert property ($rose(host_irq) |-> channel_ready && ready_forced)
        else $error("interrupt without forced ready");
    reset_idle_a: assert property ($rose(reset_n) |-> dev.read_n && dev.write_n && channel_ready && !host_irq)
        else $error("outputs not idle after reset");
endmodule // hias_sync_asserts

bind hias_sync hias_sync_asserts #(.ADDR_W(ADDR_W), .READY_MAX_CYC(READY_MAX_CYC)) u_hias_chk (
    .clock(clock), .reset_n(reset_n), .host(host), .match_value(match_value), .done_n(done_n),
    .dev(dev), .channel_ready(channel_ready), .host_irq(host_irq), .ready_forced(ready_forced));

// File: host_io_access_synchronizer_test.sv
// host_io_access_synchronizer_test: self-checking bench for hias_sync with a device model
// assumes the checker is bound in; host inputs change on rising edges
`timescale 1ns/100ps
module host_io_access_synchronizer_test;
    logic                 clock;         // device clock
    logic                 reset_n;       // active-low reset
    hias_pkg::hias_host_t host;          // host channel
    logic [7:0]           match_value;   // switch value
    logic                 stuck;         // device busy hold
    logic                 done_n;        // completion flag
    hias_pkg::hias_dev_t  dev;           // device strobes
    logic                 channel_ready; // host ready
    logic                 host_irq;      // watchdog interrupt
    logic                 ready_forced;  // forced ready
    int                   n_mismatch;
    int                   total_checks;
    int                   lo;
    int                   rl;
    logic                 cd;
    logic                 cs;
    logic                 fr;

    hias_sync DUT (.clock(clock), .reset_n(reset_n), .host(host), .match_value(match_value), .done_n(done_n),
        .dev(dev), .channel_ready(channel_ready), .host_irq(host_irq), .ready_forced(ready_forced));
    hias_dev_model u_dev (.clock(clock), .reset_n(reset_n), .dev(dev), .stuck(stuck), .done_n(done_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one host access; strobes released once ready has dropped and come back
    task automatic access(input logic rd, input logic [7:0] a, input logic a0, dk, en, q);
        logic rel;
        lo = 0; rl = 0; rel = 0; cd = 1'bx; cs = 1'b1;
        fr = 1'b0;
        @(posedge clock);
        host <= '{!rd, rd, en, q, a, a0, dk};
        repeat (30) begin
            @(posedge clock);
            if (rel) begin
                host.io_read_n <= 1'b1; host.io_write_n <= 1'b1; host.dma_ack_n <= 1'b1;
            end
            #1;
            if (!dev.chip_sel_n) cs = 1'b0;
            if (!(rd ? dev.read_n : dev.write_n)) begin lo++; cd = dev.cmd_data; end
            if (!(rd ? dev.write_n : dev.read_n)) lo += 100; // wrong strobe spoils the count
            if (!channel_ready) rl++;
            if (ready_forced) fr = 1'b1;
            if (rl > 0 && channel_ready) rel = 1;
        end
    endtask

    // outputs idle while reset is held
    task automatic t_reset();
        check(dev.read_n & dev.write_n, 1, "strobes in reset");
        check(channel_ready, 1, "ready in reset");
        check(host_irq, 0, "irq in reset");
    endtask

    // write then read to the port, command and data select
    task automatic t_port();
        for (int i = 0; i < 2; i++) begin
            access(i[0], 8'h5A, i[0], 1'b1, 1'b0, 1'b1);
            check(cs, 0, "port select");
            check(lo, 2, "strobe length");
            check(rl, 1, "wait states");
            check(cd, i[0], "command select");
        end
    endtask

    // wrong address, address enable high, qualifier low: no select
    task automatic t_nomatch();
        logic [7:0] at [3] = '{8'h5B, 8'h5A, 8'h5A};
        logic       et [3] = '{1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            access(1'b0, at[i], 1'b1, 1'b1, et[i], i != 2);
            check(cs, 1, "no select");
            check(lo + rl, 0, "no strobe or wait");
        end
    endtask

    // dma acknowledge selects and forces the data port
    task automatic t_dma();
        access(1'b0, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
        check(cs, 0, "dma select");
        check(lo, 2, "dma strobe");
        check(cd, 0, "dma data port");
    endtask

    // busy device blocks the access until the watchdog forces ready
    task automatic t_busy();
        @(posedge clock);
        stuck <= 1'b1;
        repeat (3) @(posedge clock);
        access(1'b0, 8'h5A, 1'b0, 1'b1, 1'b0, 1'b1);
        check(lo, 0, "blocked while busy");
        check(rl >= 14 && rl <= 18, 1, "forced ready time");
        check(host_irq, 1, "watchdog irq");
        check(fr, 1, "ready forced flag");
        stuck <= 1'b0;
        repeat (12) @(posedge clock);
        access(1'b1, 8'h5A, 1'b0, 1'b1, 1'b0, 1'b1);
        check(lo, 2, "access after busy");
        check(host_irq, 0, "irq cleared");
        check(fr, 0, "no forced ready");
    endtask

    // reset in mid-run once a blocked access has been forced through
    task automatic t_midreset();
        @(posedge clock);
        stuck <= 1'b1;
        repeat (2) @(posedge clock);
        host <= '{1'b1, 1'b0, 1'b0, 1'b1, 8'h5A, 1'b0, 1'b1};
        repeat (3) @(posedge clock);
        #1;
        check(channel_ready, 0, "ready held while busy");
        repeat (16) @(posedge clock);
        #1;
        check(host_irq, 1, "irq before mid reset");
        @(posedge clock);
        reset_n <= 1'b0;
        stuck   <= 1'b0;
        #1;
        check(host_irq, 0, "irq after mid reset");
        check(ready_forced, 0, "count after mid reset");
        check(channel_ready, 1, "ready after mid reset");
        @(posedge clock);
        host.io_write_n <= 1'b1;
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask

    // clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #10000;
        n_mismatch++;
        give_verdict();
    end

    // main sequence
    initial begin
        n_mismatch = 0; total_checks = 0;
        reset_n = 1'b0; stuck = 1'b0; match_value = 8'h5A;
        host = '{1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1};
        repeat (10) @(posedge clock);
        t_reset();
        reset_n <= 1'b1;
        t_port();
        t_nomatch();
        t_dma();
        t_busy();
        t_midreset();
        give_verdict();
    end
endmodule // host_io_access_synchronizer_test
